/* File: nle_pkg.sv */
// shared constants for the network led and event response block
`default_nettype none
package nle_pkg;
  localparam int EVT_FIRST = 31;
  localparam int EVT_LAST = 89;
  localparam int EVT_COUNT = EVT_LAST - EVT_FIRST + 1;
  localparam int APP_FIRST = 60;
  localparam int APP_COUNT = 8;
  localparam int APP_BASE = APP_FIRST - EVT_FIRST;
  localparam int CLK_HZ = 50_000_000;
  localparam int FLASH_HALF_MS = 100;
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
  typedef enum logic [1:0] {
    NLE_MSG = 2'h0,
    NLE_WARN = 2'h1,
    NLE_FAULT_OFF = 2'h3,
    NLE_FAULT_QS = 2'h2
  } nle_resp_t;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVT_SEL = 8'h04;
  localparam logic [7:0] OFS_EVT_CFG = 8'h08;
  localparam logic [7:0] OFS_EVT_STAT = 8'h0c;
  localparam logic [7:0] OFS_WARN_TIME = 8'h10;
  localparam logic [7:0] OFS_SUMMARY = 8'h14;
  localparam logic [7:0] OFS_LINK_STAT = 8'h18;
  localparam logic [7:0] OFS_APP_EVT = 8'h1c;
  localparam int CTRL_ACK_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic [1:0] RESP_RST = 2'h3;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [15:0] WARN_TIME_RST = 16'h000a;
  localparam logic [7:0] SUSTAIN_PKTS = 8'h04;
  localparam logic [58:0] NONCFG_DEF = 59'h000_0000_0000_001b;
  localparam logic [58:0] RESTART_DEF = 59'h000_0000_0000_0008;
endpackage
`default_nettype wire

/* File: nle_event_unit.sv */
// one monitored event: threshold, warning timer, fault latch, acknowledge
`timescale 1ns/100ps
`default_nettype none
module nle_event_unit (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cause,
  input wire logic [1:0] resp,
  input wire logic [7:0] thresh,
  input wire logic [15:0] warn_time,
  input wire logic tick,
  input wire logic ack,
  input wire logic restart,
  input wire logic needs_restart,
  output logic qual,
  output logic msg,
  output logic warn,
  output logic fault,
  output logic fault_qs
);
  logic [7:0] deb;
  logic [15:0] wcnt;
  logic is_warn;
  logic set_f;
  logic clr_f;

  assign is_warn = qual && resp == nle_pkg::NLE_WARN;
  // cause must persist past the threshold before it counts
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      deb <= 8'h00;
      qual <= 1'b0;
    end else if (!cause) begin
      deb <= 8'h00;
      qual <= 1'b0;
    end else if (deb >= thresh) begin
      qual <= 1'b1;
    end else begin
      deb <= deb + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wcnt <= 16'h0000;
    end else if (!is_warn) begin
      wcnt <= 16'h0000;
    end else if (tick && wcnt != 16'hffff) begin
      wcnt <= wcnt + 16'h0001;
    end
  end

  assign set_f = (qual && resp[1]) || (is_warn && wcnt >= warn_time);
  assign clr_f = restart || (ack && !cause && !needs_restart);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg <= 1'b0;
      warn <= 1'b0;
      fault <= 1'b0;
      fault_qs <= 1'b0;
    end else begin
      msg <= qual && resp == nle_pkg::NLE_MSG;
      warn <= is_warn && !set_f;
      // a new cause beats a clear in the same cycle
      fault <= set_f || (fault && !clr_f);
      if (set_f && !fault) begin
        fault_qs <= resp == nle_pkg::NLE_FAULT_QS;
      end else if (clr_f && !set_f) begin
        fault_qs <= 1'b0;
      end
    end
  end

  property p_restart_only;
    @(posedge sys_clk) disable iff (sys_rst) (fault && needs_restart && !restart) |=> fault;
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("restart-only fault cleared by ack");

  property p_warn_escalate;
    @(posedge sys_clk) disable iff (sys_rst) (is_warn && wcnt >= warn_time) |=> fault;
  endproperty
  a_warn_escalate: assert property (p_warn_escalate) else $error("expired warning not made a fault");

  property p_msg_harmless;
    @(posedge sys_clk) disable iff (sys_rst) (!fault && qual && resp == nle_pkg::NLE_MSG) |=> !fault;
  endproperty
  a_msg_harmless: assert property (p_msg_harmless) else $error("message event raised a fault");
endmodule
`default_nettype wire

/* File: nle_top.sv */
// network leds, event classification and apb register file
`timescale 1ns/100ps
`default_nettype none
module nle_top #(
  parameter int FLASH_CYCLES = nle_pkg::FLASH_CYCLES,
  parameter logic [nle_pkg::EVT_COUNT-1:0] NONCFG_MASK = nle_pkg::NONCFG_DEF,
  parameter logic [nle_pkg::EVT_COUNT-1:0] RESTART_MASK = nle_pkg::RESTART_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic svc_link_in,
  input wire logic svc_act_in,
  input wire logic [1:0] fb1_link_in,
  input wire logic [1:0] fb1_act_in,
  input wire logic [1:0] fb2_link_in,
  input wire logic [1:0] fb2_act_in,
  input wire logic [nle_pkg::EVT_COUNT-1:0] evt_cause,
  output logic svc_link_led,
  output logic svc_act_led,
  output logic fieldbus_in_link_activity_led,
  output logic fieldbus_out_link_activity_led,
  output logic [1:0] fb2_link_led,
  output logic [1:0] fb2_act_led,
  output logic drive_torque_off,
  output logic drive_quick_stop,
  output logic evt_msg_any,
  output logic evt_warn_any,
  output logic evt_fault_any
);
  localparam int NPIN = 10;
  localparam int NEV = nle_pkg::EVT_COUNT;

  if (FLASH_CYCLES < 2) begin : g_bad_flash
    $error("FLASH_CYCLES must be at least 2");
  end

  // pin synchronisers: a change counts once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sy1;
  logic [NPIN-1:0] sy2;
  logic [NPIN-1:0] sy3;
  logic [NPIN-1:0] pin_c;
  logic [NPIN-1:0] pin_d;
  logic [NPIN-1:0] pin_rise;
  logic [4:0] act_ev;

  assign pin_raw = {fb2_act_in, fb2_link_in, fb1_act_in, fb1_link_in, svc_act_in, svc_link_in};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      pin_c <= '0;
      pin_d <= '0;
    end else begin
      sy1 <= pin_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      pin_c <= (sy3 & ~(sy2 ^ sy3)) | (pin_c & (sy2 ^ sy3));
      pin_d <= pin_c;
    end
  end

  assign pin_rise = pin_c & ~pin_d;
  assign act_ev = {pin_rise[9:8], pin_rise[5:4], pin_rise[1]};

  // one prescaler for every flashing led keeps them all in phase
  logic [31:0] pre_cnt;
  logic tick;
  logic phase;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt <= 32'h0;
      tick <= 1'b0;
      phase <= 1'b0;
    end else if (pre_cnt == 32'(FLASH_CYCLES - 1)) begin
      pre_cnt <= 32'h0;
      tick <= 1'b1;
      phase <= ~phase;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // activity is judged per flash window; an edge in the closing cycle still counts
  logic [4:0] act_seen;
  logic [4:0] act_recent;
  logic [7:0] svc_pkts;
  logic [7:0] next_svc_pkts;
  logic svc_busy;

  assign next_svc_pkts = (act_ev[0] && svc_pkts != 8'hff) ? svc_pkts + 8'h01 : svc_pkts;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_seen <= 5'h00;
      act_recent <= 5'h00;
      svc_pkts <= 8'h00;
      svc_busy <= 1'b0;
    end else if (tick) begin
      act_recent <= act_seen | act_ev;
      act_seen <= 5'h00;
      svc_busy <= next_svc_pkts >= nle_pkg::SUSTAIN_PKTS;
      svc_pkts <= 8'h00;
    end else begin
      act_seen <= act_seen | act_ev;
      svc_pkts <= next_svc_pkts;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      svc_link_led <= 1'b0;
      svc_act_led <= 1'b0;
      fieldbus_in_link_activity_led <= 1'b0;
      fieldbus_out_link_activity_led <= 1'b0;
      fb2_link_led <= 2'h0;
      fb2_act_led <= 2'h0;
    end else begin
      svc_link_led <= pin_c[0];
      svc_act_led <= pin_c[0] && (svc_busy || (act_recent[0] && phase));
      fieldbus_in_link_activity_led <= pin_c[2] && (!act_recent[1] || phase);
      fieldbus_out_link_activity_led <= pin_c[3] && (!act_recent[2] || phase);
      fb2_link_led <= pin_c[7:6];
      fb2_act_led <= act_recent[4:3] & {2{phase}};
    end
  end

  // apb slave: one wait state, write lands at the completing edge
  logic acc;
  logic done;
  logic hit;
  logic [31:0] rd;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic cfg_we;
  logic [5:0] evt_sel;
  logic [1:0] resp [NEV];
  logic [7:0] thresh [NEV];
  logic [15:0] warn_time;
  logic [7:0] app_evt;
  logic ack;
  logic soft_rst;
  logic [NEV-1:0] cause_v;
  logic [NEV-1:0] ev_qual;
  logic [NEV-1:0] ev_msg;
  logic [NEV-1:0] ev_warn;
  logic [NEV-1:0] ev_fault;
  logic [NEV-1:0] ev_qs;
  logic [7:0] first_code;
  logic [7:0] fault_code;
  logic [1:0] sel_resp;

  assign acc = psel && penable && !pready;
  assign done = psel && penable && pready && pwrite && hit;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign cfg_we = done && paddr == nle_pkg::OFS_EVT_CFG;
  assign sel_resp = resp[evt_sel];

  always_comb begin
    hit = 1'b1;
    rd = 32'h0;
    case (paddr)
      nle_pkg::OFS_CTRL: rd = 32'h0;
      nle_pkg::OFS_EVT_SEL: rd = {26'h0, evt_sel};
      nle_pkg::OFS_EVT_CFG: rd = {16'h0, thresh[evt_sel], 6'h0, resp[evt_sel]};
      nle_pkg::OFS_EVT_STAT: rd = {8'h0, 8'(nle_pkg::EVT_FIRST + int'(evt_sel)), 10'h0, RESTART_MASK[evt_sel],
                                   NONCFG_MASK[evt_sel], ev_fault[evt_sel], ev_warn[evt_sel], ev_msg[evt_sel],
                                   cause_v[evt_sel]};
      nle_pkg::OFS_WARN_TIME: rd = {16'h0, warn_time};
      nle_pkg::OFS_SUMMARY: rd = {16'h0, fault_code, 5'h0, evt_fault_any, evt_warn_any, evt_msg_any};
      nle_pkg::OFS_LINK_STAT: rd = {22'h0, pin_c};
      nle_pkg::OFS_APP_EVT: rd = {24'h0, app_evt};
      default: hit = 1'b0;
    endcase
    wval = (rd & ~wmask) | (pwdata & wmask);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= acc && !hit;
      prdata <= (acc && !pwrite) ? rd : 32'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_sel <= 6'h00;
      warn_time <= nle_pkg::WARN_TIME_RST;
      app_evt <= 8'h00;
      ack <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      ack <= done && paddr == nle_pkg::OFS_CTRL && pstrb[0] && pwdata[nle_pkg::CTRL_ACK_BIT];
      soft_rst <= done && paddr == nle_pkg::OFS_CTRL && pstrb[0] && pwdata[nle_pkg::CTRL_RESTART_BIT];
      // out-of-range selections are dropped so the index always names an event
      if (done && paddr == nle_pkg::OFS_EVT_SEL && wval[5:0] < 6'(NEV)) begin
        evt_sel <= wval[5:0];
      end
      if (done && paddr == nle_pkg::OFS_WARN_TIME) begin
        warn_time <= wval[15:0];
      end
      if (done && paddr == nle_pkg::OFS_APP_EVT) begin
        app_evt <= wval[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NEV; i++) begin
        resp[i] <= nle_pkg::RESP_RST;
        thresh[i] <= nle_pkg::THRESH_RST;
      end
    end else begin
      for (int i = 0; i < NEV; i++) begin
        if (cfg_we && evt_sel == 6'(i) && !NONCFG_MASK[i]) begin
          resp[i] <= wval[1:0];
          thresh[i] <= wval[15:8];
        end
      end
    end
  end

  // application slots are raised by software, the rest by monitor logic
  always_comb begin
    cause_v = evt_cause;
    cause_v[nle_pkg::APP_BASE +: nle_pkg::APP_COUNT] = app_evt;
  end

  for (genvar gi = 0; gi < NEV; gi++) begin : g_evt
    nle_event_unit u_evt (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cause(cause_v[gi]),
      .resp(resp[gi]),
      .thresh(thresh[gi]),
      .warn_time(warn_time),
      .tick(tick),
      .ack(ack),
      .restart(soft_rst),
      .needs_restart(RESTART_MASK[gi]),
      .qual(ev_qual[gi]),
      .msg(ev_msg[gi]),
      .warn(ev_warn[gi]),
      .fault(ev_fault[gi]),
      .fault_qs(ev_qs[gi])
    );
  end

  // lowest numbered active fault is reported, zero when none
  always_comb begin
    first_code = 8'h00;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (ev_fault[i]) begin
        first_code = 8'(nle_pkg::EVT_FIRST + i);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_torque_off <= 1'b0;
      drive_quick_stop <= 1'b0;
      evt_msg_any <= 1'b0;
      evt_warn_any <= 1'b0;
      evt_fault_any <= 1'b0;
      fault_code <= 8'h00;
    end else begin
      drive_torque_off <= |(ev_fault & ~ev_qs);
      drive_quick_stop <= |(ev_fault & ev_qs);
      evt_msg_any <= |ev_msg;
      evt_warn_any <= |ev_warn;
      evt_fault_any <= |ev_fault;
      fault_code <= first_code;
    end
  end

  property p_svc_link;
    @(posedge sys_clk) disable iff (sys_rst) pin_d[0] |-> svc_link_led;
  endproperty
  a_svc_link: assert property (p_svc_link) else $error("service link led not on");

  property p_svc_act_off;
    @(posedge sys_clk) disable iff (sys_rst) !pin_c[0] |=> !svc_act_led;
  endproperty
  a_svc_act_off: assert property (p_svc_act_off) else $error("activity led lit without link");

  property p_svc_busy;
    @(posedge sys_clk) disable iff (sys_rst) (pin_c[0] && svc_busy) |=> svc_act_led;
  endproperty
  a_svc_busy: assert property (p_svc_busy) else $error("busy port led not steady");

  property p_fb1_steady;
    @(posedge sys_clk) disable iff (sys_rst) (pin_c[2] && !act_recent[1]) |=> fieldbus_in_link_activity_led;
  endproperty
  a_fb1_steady: assert property (p_fb1_steady) else $error("linked idle port led not on");

  property p_fb2_link;
    @(posedge sys_clk) disable iff (sys_rst) !pin_c[6] |=> !fb2_link_led[0] ##1 (fb2_link_led[0] == pin_d[6]);
  endproperty
  a_fb2_link: assert property (p_fb2_link) else $error("fieldbus link led wrong");

  property p_fb2_act;
    @(posedge sys_clk) disable iff (sys_rst) !act_recent[3] |=> !fb2_act_led[0];
  endproperty
  a_fb2_act: assert property (p_fb2_act) else $error("activity led lit without traffic");

  property p_phase;
    @(posedge sys_clk) disable iff (sys_rst) tick |-> (phase != $past(phase)) ##1 $stable(phase);
  endproperty
  a_phase: assert property (p_phase) else $error("flash phase out of step with tick");

  property p_fixed_cfg;
    @(posedge sys_clk) disable iff (sys_rst) (cfg_we && NONCFG_MASK[evt_sel]) |=> $stable(sel_resp);
  endproperty
  a_fixed_cfg: assert property (p_fixed_cfg) else $error("fixed event response changed");

  property p_fault_react;
    @(posedge sys_clk) disable iff (sys_rst) (|ev_fault) |=> (drive_torque_off || drive_quick_stop);
  endproperty
  a_fault_react: assert property (p_fault_react) else $error("fault without drive reaction");

  property p_code_range;
    @(posedge sys_clk) disable iff (sys_rst) (|ev_fault) |=> (fault_code >= 8'h1f && fault_code <= 8'h59);
  endproperty
  a_code_range: assert property (p_code_range) else $error("fault code out of range");
endmodule
`default_nettype wire

/* File: nle_peer.sv */
// far-side model: link partners on the service and both fieldbus port pairs
`timescale 1ns/100ps
`default_nettype none
module nle_peer (
  input wire logic sys_clk,
  input wire logic [4:0] up,
  input wire logic [4:0] busy,
  input wire logic [4:0] pkt,
  output logic [4:0] link,
  output logic [4:0] act
);
  logic [1:0] tog = 2'h0;
  initial begin
    link = 5'h00;
    act = 5'h00;
  end
  // a peer without link sends nothing, so traffic is gated by up
  // sustained traffic is two cycles high, two low: the pin filter drops one-cycle pulses
  always @(posedge sys_clk) begin
    tog <= tog + 2'h1;
    link <= up;
    act <= up & ((busy & {5{tog[1]}}) | pkt);
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the network led and event response block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int F = 16;
  typedef struct packed {logic wr; logic err; logic [31:0] d;} nle_exp_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, svc_link_led, svc_act_led, fb1_in_led, fb1_out_led;
  logic drive_torque_off, drive_quick_stop, evt_msg_any, evt_warn_any, evt_fault_any;
  logic [1:0] fb2_link_led, fb2_act_led;
  logic [4:0] up = 5'h00, busy = 5'h00, pkt = 5'h00, link, act, flags;
  logic [7:0] leds;
  logic [58:0] evt_cause = '0;
  int failures = 0, checks = 0, k, len, ones;
  integer seed = 32'h2f72c0a6;
  nle_exp_t exp_q[$];
  nle_exp_t e;

  assign flags = {drive_quick_stop, drive_torque_off, evt_fault_any, evt_warn_any, evt_msg_any};
  assign leds = {svc_link_led, svc_act_led, fb1_in_led, fb1_out_led, fb2_link_led, fb2_act_led};
  always #10 sys_clk = ~sys_clk;

  nle_peer peer (.sys_clk(sys_clk), .up(up), .busy(busy), .pkt(pkt), .link(link), .act(act));
  nle_top #(.FLASH_CYCLES(F)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .svc_link_in(link[0]), .svc_act_in(act[0]), .fb1_link_in(link[2:1]),
    .fb1_act_in(act[2:1]), .fb2_link_in(link[4:3]), .fb2_act_in(act[4:3]), .evt_cause(evt_cause),
    .svc_link_led(svc_link_led), .svc_act_led(svc_act_led), .fieldbus_in_link_activity_led(fb1_in_led),
    .fieldbus_out_link_activity_led(fb1_out_led), .fb2_link_led(fb2_link_led), .fb2_act_led(fb2_act_led),
    .drive_torque_off(drive_torque_off), .drive_quick_stop(drive_quick_stop), .evt_msg_any(evt_msg_any),
    .evt_warn_any(evt_warn_any), .evt_fault_any(evt_fault_any));

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic chkf(input logic [4:0] want);
    check({27'h0, flags}, {27'h0, want});
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ed,
                     input logic ee);
    int n;
    n = 0;
    exp_q.push_back({wr, ee, ed});
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      stop_test();
    end
    @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(negedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value at %0t: bus answer with nothing expected", $time);
      end else begin
        e = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, e.err});
        if (!e.wr) check(prdata, e.d);
      end
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, nle_pkg::OFS_EVT_SEL, 0, 32'h0, 1'b0);
    apb(1'b0, nle_pkg::OFS_WARN_TIME, 0, 32'h0000000a, 1'b0);
    apb(1'b0, nle_pkg::OFS_EVT_CFG, 0, 32'h3, 1'b0);
    apb(1'b1, 8'h20, 32'h5a, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 0, 32'h0, 1'b1);
    // indicators: unlinked, linked and idle, busy, single packets
    wt(40);
    check(leds, 8'h00);
    up <= 5'h1f;
    wt(4 * F);
    check(leds, 8'hbc);
    busy <= 5'h1f;
    wt(4 * F);
    ones = 0;
    for (int i = 0; i < 2 * F; i++) begin
      wt(1);
      check(32'(svc_act_led), 32'h1);
      check(32'({fb1_in_led, fb1_out_led}), 32'({fb2_act_led[0], fb2_act_led[1]}));
      ones += fb2_act_led[0];
    end
    check(ones, F);
    busy <= 5'h1e;
    for (int i = 0; i < 6 * F; i++) begin
      @(posedge sys_clk);
      // two-cycle pulse: a single-cycle one never passes the pin filter
      pkt <= (i % F < 2) ? 5'h01 : 5'h00;
      @(negedge sys_clk);
      if (i >= 3 * F) check(32'(svc_act_led), 32'(fb2_act_led[0]));
    end
    // responses of a configurable event, code 33
    apb(1'b1, nle_pkg::OFS_WARN_TIME, 2, 0, 1'b0);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, nle_pkg::OFS_EVT_SEL, 2, 0, 1'b0);
      apb(1'b1, nle_pkg::OFS_EVT_CFG, 32'h300 | r, 0, 1'b0);
      apb(1'b0, nle_pkg::OFS_EVT_CFG, 0, 32'h300 | r, 1'b0);
      len = 1 + (($random(seed) & 255) % 3);
      @(posedge sys_clk);
      evt_cause[2] <= 1'b1;
      repeat (len) @(posedge sys_clk);
      evt_cause[2] <= 1'b0;
      wt(8);
      chkf(5'h00);
      @(posedge sys_clk);
      evt_cause[2] <= 1'b1;
      wt(8);
      chkf({r == 2, r == 3, r >= 2, r == 1, r == 0});
      if (r == 1) begin
        wt(3 * F + 8);
        chkf(5'h0c);
      end
      apb(1'b1, nle_pkg::OFS_CTRL, 1, 0, 1'b0);
      wt(3);
      check(32'(evt_fault_any), 32'(r != 0));
      @(posedge sys_clk);
      evt_cause[2] <= 1'b0;
      wt(3);
      apb(1'b1, nle_pkg::OFS_CTRL, 1, 0, 1'b0);
      wt(4);
      chkf(5'h00);
    end
    // fixed event that only a restart clears, code 34
    apb(1'b1, nle_pkg::OFS_EVT_SEL, 3, 0, 1'b0);
    apb(1'b1, nle_pkg::OFS_EVT_CFG, 0, 0, 1'b0);
    apb(1'b0, nle_pkg::OFS_EVT_CFG, 0, 32'h3, 1'b0);
    @(posedge sys_clk);
    evt_cause[3] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    evt_cause[3] <= 1'b0;
    wt(6);
    chkf(5'h0c);
    apb(1'b1, nle_pkg::OFS_CTRL, 1, 0, 1'b0);
    wt(4);
    chkf(5'h0c);
    apb(1'b1, nle_pkg::OFS_CTRL, 2, 0, 1'b0);
    wt(4);
    chkf(5'h00);
    // application events come from the register, not the cause pins
    k = $random(seed) & 7;
    apb(1'b1, nle_pkg::OFS_EVT_SEL, 59, 0, 1'b0);
    apb(1'b0, nle_pkg::OFS_EVT_SEL, 0, 32'h3, 1'b0);
    @(posedge sys_clk);
    evt_cause[29 + k] <= 1'b1;
    wt(8);
    chkf(5'h00);
    @(posedge sys_clk);
    evt_cause[29 + k] <= 1'b0;
    apb(1'b1, nle_pkg::OFS_APP_EVT, 1 << k, 0, 1'b0);
    wt(8);
    chkf(5'h0c);
    apb(1'b0, nle_pkg::OFS_SUMMARY, 0, 32'h4 | ((60 + k) << 8), 1'b0);
    apb(1'b1, nle_pkg::OFS_EVT_SEL, 29 + k, 0, 1'b0);
    apb(1'b0, nle_pkg::OFS_EVT_STAT, 0, 32'h9 | ((60 + k) << 16), 1'b0);
    apb(1'b1, nle_pkg::OFS_APP_EVT, 0, 0, 1'b0);
    wt(2);
    apb(1'b1, nle_pkg::OFS_CTRL, 1, 0, 1'b0);
    wt(4);
    chkf(5'h00);
    stop_test();
  end
endmodule
`default_nettype wire
